// ===== rtl/gdl_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GDL_MAP_SVH
`define GDL_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GDL_CLK_PERIOD_PS 5000
`define GDL_MS_PS 1000000000
`define GDL_MS_CYCLES ((`GDL_MS_PS + `GDL_CLK_PERIOD_PS - 1) / `GDL_CLK_PERIOD_PS)
`define GDL_HOLD_S 5
`define GDL_HOLD_MS (`GDL_HOLD_S * 1000)
`define GDL_UPDATE_MS 75
`define GDL_TICK_W 18
`define GDL_MSCNT_W 13

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define GDL_ADDR_W 6
`define GDL_OFS_CTRL 6'h00
`define GDL_OFS_STATUS 6'h04
`define GDL_OFS_IRQ_STAT 6'h08
`define GDL_OFS_IRQ_MASK 6'h0C
`define GDL_OFS_TIME0 6'h10
`define GDL_OFS_TIME1 6'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define GDL_CTRL_ACCEPT_BIT 0
`define GDL_CTRL_RESET 1'b1
`define GDL_ST_LEFT_LSB 0
`define GDL_ST_RIGHT_LSB 8
`define GDL_ST_UP_BIT 16
`define GDL_ST_DOWN_BIT 17
`define GDL_ST_TONE_BIT 18
`define GDL_ST_BLANK_BIT 19
`define GDL_ST_STARS_BIT 20
`define GDL_ST_BUS_BIT 21
`define GDL_IRQ_W 4
`define GDL_IRQ_NEWMSG_BIT 0
`define GDL_IRQ_TIMEOUT_BIT 1
`define GDL_IRQ_BADCHAR_BIT 2
`define GDL_IRQ_LINKLOST_BIT 3
`define GDL_IRQ_MASK_RESET 4'h0

// ----------------------------------------------------------------
// Message encodings
// ----------------------------------------------------------------
`define GDL_CHAR_SPACE 8'h20
`define GDL_CHAR_STAR 8'h2A
`define GDL_CHAR_DASH 8'h2D
`define GDL_CHAR_0 8'h30
`define GDL_CHAR_9 8'h39
`define GDL_CHAR_A 8'h41
`define GDL_CHAR_Z 8'h5A
`define GDL_CTRL_BYTE7 8'h00
`define GDL_TONE_ON 2'h1

`endif

// ===== rtl/gdl_pkg.sv
// Types shared by the gear display controller
`default_nettype none
package gdl_pkg;

	// Gray codes: down -> blank -> showing
	typedef enum logic [1:0] {
		GDL_LINK_DOWN = 2'h0,
		GDL_BLANK = 2'h1,
		GDL_SHOWING = 2'h3
	} gdl_link_t;

	typedef struct packed {
		logic busMeta;
		logic busSync;
		logic waitReq;
		logic [31:0] readData;
		logic acceptEn;
		logic [3:0] irqStat;
		logic [3:0] irqMask;
		logic [31:0] time0;
		logic [31:0] time1;
		logic [17:0] tick;
		logic [12:0] msCount;
		gdl_link_t link;
		logic [7:0] leftChar;
		logic [7:0] rightChar;
		logic upArrow;
		logic downArrow;
		logic toneOn;
		logic blank;
		logic stars;
		logic irq;
		logic tdValid;
		logic [63:0] tdData;
	} gdl_state_t;

endpackage
`default_nettype wire

// ===== rtl/gdl_display_ctrl.sv
// In-cab gear display controller with Avalon-MM status and control
`timescale 1ns/1ps
`default_nettype none
`include "gdl_map.svh"

module gdl_display_ctrl #(
	parameter int unsigned MS_TICK_CYCLES = `GDL_MS_CYCLES,
	parameter int unsigned HOLD_MS = `GDL_HOLD_MS
) (
	input wire logic clock,
	input wire logic rstn,
	// Avalon-MM slave
	input wire logic [5:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output logic irq,
	// Link side
	input wire logic busActive,
	input wire logic msgValid,
	input wire logic msgFromJ1587,
	input wire logic [7:0] msgByte7,
	input wire logic [7:0] msgByte8,
	input wire logic tdRequest,
	output logic tdValid,
	output logic [63:0] tdData,
	// Display
	output logic [7:0] leftChar,
	output logic [7:0] rightChar,
	output logic upArrow,
	output logic downArrow,
	output logic toneOn,
	output logic blank,
	output logic showStars
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic charSupported(input logic [7:0] c);
		return (c >= `GDL_CHAR_A && c <= `GDL_CHAR_Z) ||
			(c >= `GDL_CHAR_0 && c <= `GDL_CHAR_9) ||
			c == `GDL_CHAR_SPACE || c == `GDL_CHAR_DASH;
	endfunction

	function automatic logic [31:0] applyBe(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	localparam logic [17:0] TICK_LAST = 18'(MS_TICK_CYCLES - 1);
	localparam logic [12:0] HOLD_LAST = 13'(HOLD_MS - 1);

	gdl_pkg::gdl_state_t cur;
	gdl_pkg::gdl_state_t nxt;

	logic msTick;
	logic isCtrl;
	logic charOk;
	logic takeMsg;
	logic reqTaken;
	logic [31:0] statusWord;
	logic [3:0] irqSet;
	logic [3:0] irqClr;

	assign msTick = (cur.tick == TICK_LAST);
	// Messages from either link share one path
	assign takeMsg = msgValid && cur.busSync && cur.acceptEn;
	assign isCtrl = (msgByte7 == `GDL_CTRL_BYTE7);
	assign charOk = charSupported(msgByte7) && charSupported(msgByte8);
	assign reqTaken = (avsRead || avsWrite) && !cur.waitReq;

	always_comb begin
		statusWord = 32'h0;
		statusWord[`GDL_ST_LEFT_LSB +: 8] = cur.leftChar;
		statusWord[`GDL_ST_RIGHT_LSB +: 8] = cur.rightChar;
		statusWord[`GDL_ST_UP_BIT] = cur.upArrow;
		statusWord[`GDL_ST_DOWN_BIT] = cur.downArrow;
		statusWord[`GDL_ST_TONE_BIT] = cur.toneOn;
		statusWord[`GDL_ST_BLANK_BIT] = cur.blank;
		statusWord[`GDL_ST_STARS_BIT] = cur.stars;
		statusWord[`GDL_ST_BUS_BIT] = cur.busSync;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt = cur;
		irqSet = 4'h0;
		irqClr = 4'h0;
		nxt.busMeta = busActive;
		nxt.busSync = cur.busMeta;
		// Restart the ms tick on each message so the hold is never short
		nxt.tick = (msTick || takeMsg) ? 18'h0 : cur.tick + 18'h1;
		nxt.tdValid = 1'b0;

		// Bus slave: answer one cycle after the request appears
		nxt.waitReq = 1'b1;
		if ((avsRead || avsWrite) && cur.waitReq) begin
			nxt.waitReq = 1'b0;
			nxt.readData = 32'h0;
			if (avsRead) begin
				unique case (avsAddress)
					`GDL_OFS_CTRL: nxt.readData = {31'h0, cur.acceptEn};
					`GDL_OFS_STATUS: nxt.readData = statusWord;
					`GDL_OFS_IRQ_STAT: nxt.readData = {28'h0, cur.irqStat};
					`GDL_OFS_IRQ_MASK: nxt.readData = {28'h0, cur.irqMask};
					`GDL_OFS_TIME0: nxt.readData = cur.time0;
					`GDL_OFS_TIME1: nxt.readData = cur.time1;
					default: nxt.readData = 32'h0;
				endcase
			end
		end
		if (reqTaken && avsWrite) begin
			unique case (avsAddress)
				`GDL_OFS_CTRL: begin
					if (avsByteEnable[0]) begin
						nxt.acceptEn = avsWriteData[`GDL_CTRL_ACCEPT_BIT];
					end
				end
				`GDL_OFS_IRQ_MASK: begin
					if (avsByteEnable[0]) begin
						nxt.irqMask = avsWriteData[3:0];
					end
				end
				`GDL_OFS_TIME0: nxt.time0 = applyBe(cur.time0, avsWriteData,
					avsByteEnable);
				`GDL_OFS_TIME1: nxt.time1 = applyBe(cur.time1, avsWriteData,
					avsByteEnable);
				default: ;
			endcase
		end
		// Only the bits actually returned are cleared, so later events survive
		if (reqTaken && avsRead && avsAddress == `GDL_OFS_IRQ_STAT) begin
			irqClr = cur.readData[3:0];
		end

		// Time and date answer, all eight byte fields in one word
		if (tdRequest) begin
			nxt.tdValid = 1'b1;
			nxt.tdData = {cur.time1, cur.time0};
		end

		// Display path; takes messages only once busSync is high, which reset clears
		if (cur.link != gdl_pkg::GDL_LINK_DOWN && msTick &&
				cur.msCount != HOLD_LAST) begin
			nxt.msCount = cur.msCount + 13'h1;
		end
		if (!cur.busSync) begin
			if (cur.link != gdl_pkg::GDL_LINK_DOWN) begin
				irqSet[`GDL_IRQ_LINKLOST_BIT] = 1'b1;
			end
			nxt.link = gdl_pkg::GDL_LINK_DOWN;
			nxt.leftChar = `GDL_CHAR_STAR;
			nxt.rightChar = `GDL_CHAR_STAR;
			nxt.upArrow = 1'b0;
			nxt.downArrow = 1'b0;
			nxt.toneOn = 1'b0;
			nxt.blank = 1'b0;
			nxt.stars = 1'b1;
			nxt.msCount = 13'h0;
		end else if (takeMsg && isCtrl) begin
			// Characters stay; reserved upper bits are not looked at
			nxt.upArrow = msgByte8[0];
			nxt.downArrow = msgByte8[1];
			nxt.toneOn = (msgByte8[3:2] == `GDL_TONE_ON);
			nxt.msCount = 13'h0;
			irqSet[`GDL_IRQ_NEWMSG_BIT] = 1'b1;
		end else if (takeMsg && charOk) begin
			nxt.link = gdl_pkg::GDL_SHOWING;
			nxt.leftChar = msgByte7;
			nxt.rightChar = msgByte8;
			nxt.blank = 1'b0;
			nxt.stars = 1'b0;
			nxt.msCount = 13'h0;
			irqSet[`GDL_IRQ_NEWMSG_BIT] = 1'b1;
		end else if (takeMsg || cur.link == gdl_pkg::GDL_LINK_DOWN ||
				(cur.link == gdl_pkg::GDL_SHOWING && msTick &&
				cur.msCount == HOLD_LAST)) begin
			if (takeMsg) begin
				irqSet[`GDL_IRQ_BADCHAR_BIT] = 1'b1;
			end else if (cur.link == gdl_pkg::GDL_SHOWING) begin
				irqSet[`GDL_IRQ_TIMEOUT_BIT] = 1'b1;
			end
			nxt.link = gdl_pkg::GDL_BLANK;
			nxt.leftChar = `GDL_CHAR_SPACE;
			nxt.rightChar = `GDL_CHAR_SPACE;
			nxt.upArrow = 1'b0;
			nxt.downArrow = 1'b0;
			nxt.toneOn = 1'b0;
			nxt.blank = 1'b1;
			nxt.stars = 1'b0;
			nxt.msCount = 13'h0;
		end

		// Set wins over a clear in the same cycle
		nxt.irqStat = (cur.irqStat & ~irqClr) | irqSet;
		nxt.irq = |(nxt.irqStat & cur.irqMask);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rstn) begin
			cur <= '0;
			cur.waitReq <= 1'b1;
			cur.acceptEn <= `GDL_CTRL_RESET;
			cur.irqMask <= `GDL_IRQ_MASK_RESET;
			cur.link <= gdl_pkg::GDL_LINK_DOWN;
			cur.leftChar <= `GDL_CHAR_STAR;
			cur.rightChar <= `GDL_CHAR_STAR;
			cur.stars <= 1'b1;
		end else begin
			cur <= nxt;
		end
	end

	// Two character cells, two arrows, tone, blank, stars, interrupt, Avalon and time and date outputs
	assign leftChar = cur.leftChar;
	assign rightChar = cur.rightChar;
	assign upArrow = cur.upArrow;
	assign downArrow = cur.downArrow;
	assign toneOn = cur.toneOn;
	assign blank = cur.blank;
	assign showStars = cur.stars;
	assign irq = cur.irq;
	assign avsReadData = cur.readData;
	assign avsWaitRequest = cur.waitReq;
	assign tdValid = cur.tdValid;
	assign tdData = cur.tdData;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_CHAR_UPDATE: assert property (@(posedge clock) disable iff (!rstn)
		cur.busSync && takeMsg && !isCtrl && charOk |=>
		leftChar == $past(msgByte7) && rightChar == $past(msgByte8) &&
		!blank) else $error("character message not shown next cycle");

	AST_CTRL_KEEP: assert property (@(posedge clock) disable iff (!rstn)
		cur.busSync && takeMsg && isCtrl |=>
		$stable(leftChar) && $stable(rightChar))
		else $error("control message changed characters");

	AST_ARROWS: assert property (@(posedge clock) disable iff (!rstn)
		cur.busSync && takeMsg && isCtrl |=>
		upArrow == $past(msgByte8[0]) && downArrow == $past(msgByte8[1]))
		else $error("arrow bits not applied");

	AST_TONE: assert property (@(posedge clock) disable iff (!rstn)
		cur.busSync && takeMsg && isCtrl && msgByte8[3] |=> !toneOn)
		else $error("undefined tone pattern turned tone on");

	AST_STARS: assert property (@(posedge clock) disable iff (!rstn)
		!cur.busSync |=> showStars && leftChar == `GDL_CHAR_STAR &&
		rightChar == `GDL_CHAR_STAR) else $error("stars missing bus down");

	AST_BADCHAR: assert property (@(posedge clock) disable iff (!rstn)
		cur.busSync && takeMsg && !isCtrl && !charOk |=> blank && !showStars)
		else $error("unsupported character not blanked");

	AST_HOLD: assert property (@(posedge clock) disable iff (!rstn)
		cur.link == gdl_pkg::GDL_SHOWING && cur.busSync && !takeMsg &&
		cur.msCount != HOLD_LAST |=> !blank)
		else $error("message blanked before hold time");

	AST_TIMEOUT: assert property (@(posedge clock) disable iff (!rstn)
		cur.link == gdl_pkg::GDL_SHOWING && cur.busSync && !takeMsg &&
		msTick && cur.msCount == HOLD_LAST |=> blank)
		else $error("silence did not blank display");

	AST_TD_ANSWER: assert property (@(posedge clock) disable iff (!rstn)
		tdRequest |=> tdValid && tdData == {$past(cur.time1), $past(cur.time0)})
		else $error("time and date answer wrong");

endmodule // gdl_display_ctrl
`default_nettype wire

// ===== test/gdl_sender.sv
// Behavioural transmission controller feeding the gear display link
`timescale 1ns/1ps
`default_nettype none

module gdl_sender (
	input wire logic clock,
	output logic msgValid,
	output logic msgFromJ1587,
	output logic [7:0] msgByte7,
	output logic [7:0] msgByte8,
	output logic tdRequest
);
	initial begin
		msgValid = 1'b0;
		msgFromJ1587 = 1'b0;
		msgByte7 = 8'hA5;
		msgByte8 = 8'h5A;
		tdRequest = 1'b0;
	end

	// Bytes are inverted after each message so stale values never look valid
	task automatic send(input logic [7:0] b7, input logic [7:0] b8,
		input logic src);
		@(posedge clock);
		msgValid <= 1'b1;
		msgFromJ1587 <= src;
		msgByte7 <= b7;
		msgByte8 <= b8;
		@(posedge clock);
		msgValid <= 1'b0;
		msgByte7 <= ~b7;
		msgByte8 <= ~b8;
	endtask

	task automatic sendGear(input logic [7:0] c);
		send(8'h20, c, 1'b0);
	endtask

	// Reserved upper bits always go out as ones
	task automatic sendCtrl(input logic [1:0] arrows, input logic [1:0] tone);
		send(8'h00, {4'hF, tone, arrows}, 1'b1);
	endtask

	task automatic askTime;
		@(posedge clock);
		tdRequest <= 1'b1;
		@(posedge clock);
		tdRequest <= 1'b0;
	endtask
endmodule // gdl_sender

`default_nettype wire

// ===== test/test_gear_display_message_link.sv
// Self-checking bench for the gear display controller
`timescale 1ns/1ps
`default_nettype none
`include "gdl_map.svh"

module test_gear_display_message_link;
	localparam int unsigned TICK = 10;
	localparam int unsigned HOLD = 4;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [5:0] avsAddress = 6'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0;
	logic [3:0] avsByteEnable = 4'h0;
	logic busActive = 1'b0;
	logic [31:0] avsReadData;
	logic avsWaitRequest, irq, msgValid, msgFromJ1587, tdRequest, tdValid;
	logic [7:0] msgByte7, msgByte8, leftChar, rightChar;
	logic [63:0] tdData;
	logic upArrow, downArrow, toneOn, blank, showStars;
	logic [31:0] rd;
	logic [7:0] bad [6] = '{8'h2F, 8'h3A, 8'h40, 8'h5B, 8'h61, 8'h2A};
	int fails = 0;
	int checked = 0;

	always #2.5 clock = ~clock;

	gdl_display_ctrl #(.MS_TICK_CYCLES(TICK), .HOLD_MS(HOLD)) i_gdl_display_ctrl (
		.clock(clock), .rstn(rstn), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
		.avsWaitRequest(avsWaitRequest), .irq(irq), .busActive(busActive),
		.msgValid(msgValid), .msgFromJ1587(msgFromJ1587),
		.msgByte7(msgByte7), .msgByte8(msgByte8), .tdRequest(tdRequest),
		.tdValid(tdValid), .tdData(tdData), .leftChar(leftChar),
		.rightChar(rightChar), .upArrow(upArrow), .downArrow(downArrow),
		.toneOn(toneOn), .blank(blank), .showStars(showStars));

	gdl_sender i_gdl_sender (
		.clock(clock), .msgValid(msgValid), .msgFromJ1587(msgFromJ1587),
		.msgByte7(msgByte7), .msgByte8(msgByte8), .tdRequest(tdRequest));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; held until waitrequest is seen low at an edge
	task automatic av(input logic wr, input logic [5:0] a,
		input logic [31:0] wd, input logic [3:0] be, output logic [31:0] d);
		@(posedge clock);
		avsAddress <= a;
		avsRead <= ~wr;
		avsWrite <= wr;
		avsWriteData <= wd;
		avsByteEnable <= be;
		// Only the watchdog ends a wait that never sees the answer
		do begin
			@(posedge clock);
		end while (avsWaitRequest !== 1'b0);
		d = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
	endtask

	task automatic waitNeg(input int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic wrap_up;
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		fails++;
		wrap_up();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		waitNeg(1);
		chk({leftChar, rightChar, showStars, blank}, {16'h2A2A, 2'b10});
		av(1'b0, `GDL_OFS_CTRL, 32'h0, 4'hF, rd);
		chk(rd, 32'h1);
		av(1'b0, 6'h3C, 32'h0, 4'hF, rd);
		chk(rd, 32'h0);
		busActive <= 1'b1;
		waitNeg(6);
		chk({showStars, blank}, 2'b01);
		av(1'b1, `GDL_OFS_IRQ_MASK, 32'h1, 4'hF, rd);
		av(1'b0, `GDL_OFS_IRQ_STAT, 32'h0, 4'hF, rd);
		i_gdl_sender.send(8'h31, 8'h32, 1'b1);
		waitNeg(1);
		chk({leftChar, rightChar, blank}, {16'h3132, 1'b0});
		waitNeg(1);
		chk(irq, 1'b1);
		av(1'b0, `GDL_OFS_IRQ_STAT, 32'h0, 4'hF, rd);
		waitNeg(2);
		chk({rd[0], irq}, 2'b10);
		i_gdl_sender.sendGear(8'h4E);
		waitNeg(1);
		chk({leftChar, rightChar}, 16'h204E);
		for (int a = 0; a < 4; a++) begin
			for (int t = 0; t < 4; t++) begin
				i_gdl_sender.sendCtrl(a[1:0], t[1:0]);
				waitNeg(1);
				chk({leftChar, rightChar, upArrow, downArrow, toneOn},
					{16'h204E, a[0], a[1], t == 1});
			end
		end
		i_gdl_sender.send(8'h00, 8'h05, 1'b0);
		waitNeg(1);
		chk({upArrow, downArrow, toneOn}, 3'b101);
		av(1'b0, `GDL_OFS_STATUS, 32'h0, 4'hF, rd);
		chk(rd, 32'h00254E20);
		// Character set edges, the bad one alternating between positions
		foreach (bad[i]) begin
			i_gdl_sender.send(8'h2D, 8'h5A, 1'b0);
			waitNeg(1);
			chk({leftChar, rightChar, blank}, {16'h2D5A, 1'b0});
			i_gdl_sender.send(i[0] ? bad[i] : 8'h30, i[0] ? 8'h30 : bad[i], i[0]);
			waitNeg(1);
			chk(blank, 1'b1);
		end
		av(1'b0, `GDL_OFS_IRQ_STAT, 32'h0, 4'hF, rd);
		chk(rd[2], 1'b1);
		i_gdl_sender.send(8'h31, 8'h30, 1'b1);
		i_gdl_sender.sendCtrl(2'b11, 2'b01);
		waitNeg(TICK * HOLD);
		chk({leftChar, rightChar, blank}, {16'h3130, 1'b0});
		waitNeg(1);
		chk({leftChar, rightChar, blank, upArrow, downArrow, toneOn},
			{16'h2020, 4'b1000});
		av(1'b0, `GDL_OFS_IRQ_STAT, 32'h0, 4'hF, rd);
		chk(rd[1], 1'b1);
		av(1'b1, `GDL_OFS_CTRL, 32'h0, 4'h1, rd);
		i_gdl_sender.send(8'h33, 8'h33, 1'b0);
		waitNeg(2);
		chk({leftChar, rightChar, blank}, {16'h2020, 1'b1});
		av(1'b1, `GDL_OFS_CTRL, 32'h1, 4'h1, rd);
		// Only the low lane of the last TIME0 write may land
		av(1'b1, `GDL_OFS_TIME0, 32'h0B172D3A, 4'hF, rd);
		av(1'b1, `GDL_OFS_TIME1, 32'hFB001806, 4'hF, rd);
		av(1'b1, `GDL_OFS_TIME0, 32'hFFFFFF05, 4'h1, rd);
		i_gdl_sender.askTime();
		waitNeg(1);
		chk(tdValid, 1'b1);
		chk(tdData, 64'hFB0018060B172D05);
		waitNeg(1);
		chk(tdValid, 1'b0);
		i_gdl_sender.send(8'h20, 8'h31, 1'b1);
		av(1'b0, `GDL_OFS_IRQ_STAT, 32'h0, 4'hF, rd);
		busActive <= 1'b0;
		waitNeg(5);
		i_gdl_sender.send(8'h31, 8'h32, 1'b0);
		waitNeg(2);
		chk({showStars, irq}, 2'b10);
		av(1'b0, `GDL_OFS_IRQ_STAT, 32'h0, 4'hF, rd);
		chk(rd[3], 1'b1);
		wrap_up();
	end
endmodule // test_gear_display_message_link

`default_nettype wire
